/* rtl/lvf_pkg.sv */
// Shared constants, types and helpers for the vertical sync and fetch address block
`default_nettype none
package lvf_pkg;
  // Register byte offsets
  localparam logic [7:0] LVF_OFS_MODE       = 8'h10;
  localparam logic [7:0] LVF_OFS_VSYNC      = 8'h3c;
  localparam logic [7:0] LVF_OFS_MAIN_START = 8'h40;
  localparam logic [7:0] LVF_OFS_MAIN_LINE  = 8'h44;
  localparam logic [7:0] LVF_OFS_OVL_START  = 8'h50;
  localparam logic [7:0] LVF_OFS_OVL_LINE   = 8'h54;
  localparam logic [7:0] LVF_OFS_OVL_X      = 8'h58;
  localparam logic [7:0] LVF_OFS_OVL_Y      = 8'h5c;
  localparam logic [7:0] LVF_OFS_VTIMING    = 8'h70;
  localparam logic [7:0] LVF_OFS_VDISP      = 8'h74;
  localparam logic [7:0] LVF_OFS_STATUS     = 8'h78;
  // Field layout
  localparam int unsigned LVF_VS_POL_BIT   = 23;
  localparam int unsigned LVF_VS_WIDTH_LSB = 16;
  localparam int unsigned LVF_VS_WIDTH_W   = 3;
  localparam int unsigned LVF_POS_W        = 10;
  localparam int unsigned LVF_HI_LSB       = 16;
  localparam int unsigned LVF_ADDR_W       = 17;
  localparam int unsigned LVF_LINE_OFS_W   = 10;
  localparam int unsigned LVF_OVL_EN_BIT   = 19;
  // Writable bits; everything else reads as zero
  localparam logic [31:0] LVF_MASK_MODE  = 32'h0008_0000;
  localparam logic [31:0] LVF_MASK_VSYNC = 32'h0087_03ff;
  localparam logic [31:0] LVF_MASK_ADDR  = 32'h0001_ffff;
  localparam logic [31:0] LVF_MASK_LINE  = 32'h0000_03ff;
  localparam logic [31:0] LVF_MASK_POS   = 32'h03ff_03ff;
  // Reset values
  localparam logic [31:0] LVF_RST_REG    = 32'h0000_0000;
  localparam logic        LVF_RST_PIN    = 1'b1;
  // Bus answers
  localparam logic [1:0]  LVF_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  LVF_RESP_SLVERR = 2'b10;

  typedef enum logic [0:0] {
    LVF_IDLE = 1'b0,
    LVF_BUSY = 1'b1
  } lvf_bus_e;

  // Byte-lane merge of a write into a register, reserved bits kept zero
  function automatic logic [31:0] lvf_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb,
                                            input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction : lvf_merge

  function automatic logic lvf_in_range(input logic [10:0] v,
                                        input logic [10:0] lo,
                                        input logic [10:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : lvf_in_range
endpackage : lvf_pkg
`default_nettype wire

/* rtl/lvf_vsync_gen.sv */
// Panel vertical sync pulse generator
`default_nettype none
module lvf_vsync_gen
  import lvf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       line_strobe,
  input  wire logic [9:0] line_next,
  input  wire logic [9:0] vsync_start_line,
  input  wire logic [2:0] vsync_width,
  input  wire logic       vsync_polarity,
  output logic            panel_vertical_sync
);
  typedef struct packed {
    logic       active;
    logic [2:0] left;
    logic [3:0] held;
    logic       pin;
  } lvf_vs_s;

  lvf_vs_s q;
  lvf_vs_s next_q;

  always_comb begin
    next_q     = q;
    next_q.pin = q.active ~^ vsync_polarity;
    if (line_strobe) begin
      if (line_next == vsync_start_line) begin
        next_q.active = 1'b1;
        next_q.left   = vsync_width;
        next_q.held   = 4'h1;
      end else if (q.active) begin
        if (q.left == 3'h0) begin
          next_q.active = 1'b0;
        end else begin
          next_q.left = q.left - 3'h1;
          next_q.held = q.held + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{active: 1'b0, left: 3'h0, held: 4'h0, pin: LVF_RST_PIN};
    end else begin
      q <= next_q;
    end
  end

  assign panel_vertical_sync = q.pin;

  a_pin_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 panel_vertical_sync == ($past(q.active) ~^ $past(vsync_polarity)))
    else $error("vertical sync pin polarity wrong");
  a_sync_start: assert property (@(posedge mclk) disable iff (!rst_n)
    line_strobe && line_next == vsync_start_line |=> q.active ##1 panel_vertical_sync
      == vsync_polarity)
    else $error("vertical sync did not start at the start line");
  a_sync_width: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(q.active) |-> q.held == {1'b0, vsync_width} + 4'h1)
    else $error("vertical sync width differs from field plus one");
endmodule : lvf_vsync_gen
`default_nettype wire

/* rtl/lvf_fetch_addr.sv */
// Line-by-line display buffer fetch address stepper
`default_nettype none
module lvf_fetch_addr
  import lvf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic        step,
  input  wire logic [16:0] base_addr,
  input  wire logic [9:0]  line_offset,
  output logic [16:0]      fetch_addr
);
  typedef struct packed {
    logic [16:0] addr;
  } lvf_fa_s;

  lvf_fa_s q;
  lvf_fa_s next_q;

  always_comb begin
    next_q = q;
    if (load) begin
      next_q.addr = base_addr;
    end else if (step) begin
      // Offset wider than the visible line skips the rest of a virtual line
      next_q.addr = q.addr + {7'h00, line_offset};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{addr: 17'h00000};
    end else begin
      q <= next_q;
    end
  end

  assign fetch_addr = q.addr;

  a_load_base: assert property (@(posedge mclk) disable iff (!rst_n)
    load |=> fetch_addr == $past(base_addr))
    else $error("fetch address not loaded from start address");
  a_step_offset: assert property (@(posedge mclk) disable iff (!rst_n)
    step && !load |=> fetch_addr == 17'($past(fetch_addr) + {7'h00, $past(line_offset)}))
    else $error("fetch address not advanced by line offset");
endmodule : lvf_fetch_addr
`default_nettype wire

/* rtl/lvf_core.sv */
// Vertical sync and fetch address block with its AXI4-Lite register file
// Function
// - Vertical sync pin is active low when the polarity bit is 0 and active high when it is 1.
// - Vertical sync stays active for the 3-bit width field plus one lines.
// - Vertical sync starts at the line given by the 10-bit start field, one-line resolution.
// - Main window fetch begins at the 17-bit word address, zero being the first word.
// - Main fetch address advances by the 10-bit word offset from one line to the next.
// - An offset wider than the visible line shows a window into a wider image.
// - Overlay fetch begins at its own 17-bit word address, zero being the first word.
// - The overlay start address does nothing unless the mode overlay enable bit 19 is 1.
// - Overlay fetch address steps by a 10-bit word offset between overlay lines.
// - Overlay address, offset and position writes apply after a Y write, at the next blank line.
// - The overlay X register holds end position in bits 25-16 and start in bits 9-0.
`default_nettype none
module lvf_core
  import lvf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        line_strobe,
  output logic             panel_vertical_sync,
  output logic             vertical_non_display,
  output logic [16:0]      main_fetch_addr,
  output logic [16:0]      overlay_fetch_addr,
  output logic             overlay_fetch_en,
  output logic [9:0]       overlay_x_start,
  output logic [9:0]       overlay_x_end
);
  typedef struct packed {
    lvf_bus_e    wst;
    lvf_bus_e    rst;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] mode;
    logic [31:0] vsync;
    logic [31:0] main_start;
    logic [31:0] main_line;
    logic [31:0] ovl_start;
    logic [31:0] ovl_line;
    logic [31:0] ovl_x;
    logic [31:0] ovl_y;
    logic [31:0] vtiming;
    logic [31:0] vdisp;
    logic [16:0] act_start;
    logic [9:0]  act_line;
    logic [31:0] act_x;
    logic [31:0] act_y;
    logic        commit_pend;
    logic [9:0]  line;
    logic        blank;
    logic        ovl_on;
  } lvf_main_s;

  lvf_main_s   q;
  lvf_main_s   next_q;
  logic        wr;
  logic        rd;
  logic        ypos_wr;
  logic [7:0]  wa;
  logic [7:0]  ra;
  logic [9:0]  vt;
  logic [9:0]  vds;
  logic [9:0]  line_n;
  logic [10:0] disp_end;
  logic [10:0] oy_lo;
  logic [10:0] oy_hi;
  logic        in_disp_n;
  logic        ovl_en;
  logic        ovl_hit_n;
  logic        main_load;
  logic        main_step;
  logic        ovl_load;
  logic        ovl_step;

  // Address and data are taken together, so no half-taken write needs holding
  assign awready = (q.wst == LVF_IDLE) && awvalid && wvalid;
  assign wready  = awready;
  assign bvalid  = (q.wst == LVF_BUSY);
  assign bresp   = q.bresp;
  assign arready = (q.rst == LVF_IDLE);
  assign rvalid  = (q.rst == LVF_BUSY);
  assign rresp   = q.rresp;
  assign rdata   = q.rdata;
  assign wr      = awvalid && awready;
  assign rd      = arvalid && arready;
  assign wa      = {awaddr[7:2], 2'b00};
  assign ra      = {araddr[7:2], 2'b00};
  assign ypos_wr = wr && (wa == LVF_OFS_OVL_Y);

  assign vt       = q.vtiming[LVF_POS_W-1:0];
  assign vds      = q.vdisp[LVF_POS_W-1:0];
  assign line_n   = (q.line == vt) ? 10'h000 : q.line + 10'h001;
  assign disp_end = {1'b0, vds} + {1'b0, q.vtiming[LVF_HI_LSB +: LVF_POS_W]};
  assign in_disp_n = lvf_in_range({1'b0, line_n}, {1'b0, vds}, disp_end);
  // Overlay lines are counted from the first display line
  assign oy_lo    = {1'b0, vds} + {1'b0, q.act_y[LVF_POS_W-1:0]};
  assign oy_hi    = {1'b0, vds} + {1'b0, q.act_y[LVF_HI_LSB +: LVF_POS_W]};
  assign ovl_en   = q.mode[LVF_OVL_EN_BIT];
  assign ovl_hit_n = ovl_en && in_disp_n
                     && lvf_in_range({1'b0, line_n}, oy_lo, oy_hi);

  assign main_load = line_strobe && (line_n == vds);
  assign main_step = line_strobe && in_disp_n && !main_load;
  assign ovl_load  = line_strobe && ovl_hit_n && ({1'b0, line_n} == oy_lo);
  assign ovl_step  = line_strobe && ovl_hit_n && !ovl_load;

  always_comb begin
    next_q = q;
    if (wr) begin
      next_q.wst   = LVF_BUSY;
      next_q.bresp = LVF_RESP_OKAY;
      unique case (wa)
        LVF_OFS_MODE:       next_q.mode = lvf_merge(q.mode, wdata, wstrb, LVF_MASK_MODE);
        LVF_OFS_VSYNC:      next_q.vsync = lvf_merge(q.vsync, wdata, wstrb, LVF_MASK_VSYNC);
        LVF_OFS_MAIN_START: begin
          next_q.main_start = lvf_merge(q.main_start, wdata, wstrb, LVF_MASK_ADDR);
        end
        LVF_OFS_MAIN_LINE:  begin
          next_q.main_line = lvf_merge(q.main_line, wdata, wstrb, LVF_MASK_LINE);
        end
        LVF_OFS_OVL_START:  begin
          next_q.ovl_start = lvf_merge(q.ovl_start, wdata, wstrb, LVF_MASK_ADDR);
        end
        LVF_OFS_OVL_LINE:   begin
          next_q.ovl_line = lvf_merge(q.ovl_line, wdata, wstrb, LVF_MASK_LINE);
        end
        LVF_OFS_OVL_X:      next_q.ovl_x = lvf_merge(q.ovl_x, wdata, wstrb, LVF_MASK_POS);
        LVF_OFS_OVL_Y:      next_q.ovl_y = lvf_merge(q.ovl_y, wdata, wstrb, LVF_MASK_POS);
        LVF_OFS_VTIMING:    begin
          next_q.vtiming = lvf_merge(q.vtiming, wdata, wstrb, LVF_MASK_POS);
        end
        LVF_OFS_VDISP:      next_q.vdisp = lvf_merge(q.vdisp, wdata, wstrb, LVF_MASK_LINE);
        // Status is read-only: a write is answered OKAY and dropped
        LVF_OFS_STATUS:     next_q.bresp = LVF_RESP_OKAY;
        default:            next_q.bresp = LVF_RESP_SLVERR;
      endcase
    end else if (bready && (q.wst == LVF_BUSY)) begin
      next_q.wst = LVF_IDLE;
    end

    if (rd) begin
      next_q.rst   = LVF_BUSY;
      next_q.rresp = LVF_RESP_OKAY;
      unique case (ra)
        LVF_OFS_MODE:       next_q.rdata = q.mode;
        LVF_OFS_VSYNC:      next_q.rdata = q.vsync;
        LVF_OFS_MAIN_START: next_q.rdata = q.main_start;
        LVF_OFS_MAIN_LINE:  next_q.rdata = q.main_line;
        LVF_OFS_OVL_START:  next_q.rdata = q.ovl_start;
        LVF_OFS_OVL_LINE:   next_q.rdata = q.ovl_line;
        LVF_OFS_OVL_X:      next_q.rdata = q.ovl_x;
        LVF_OFS_OVL_Y:      next_q.rdata = q.ovl_y;
        LVF_OFS_VTIMING:    next_q.rdata = q.vtiming;
        LVF_OFS_VDISP:      next_q.rdata = q.vdisp;
        LVF_OFS_STATUS:     next_q.rdata = {20'h00000, q.commit_pend, q.blank, q.line};
        default: begin
          next_q.rdata = 32'h0000_0000;
          next_q.rresp = LVF_RESP_SLVERR;
        end
      endcase
    end else if (rready && (q.rst == LVF_BUSY)) begin
      next_q.rst = LVF_IDLE;
    end

    if (line_strobe) begin
      next_q.line   = line_n;
      next_q.blank  = !in_disp_n;
      next_q.ovl_on = ovl_hit_n;
      // Overlay settings swap only on a blank line so a frame never tears
      if (q.commit_pend && !in_disp_n) begin
        next_q.act_start   = q.ovl_start[LVF_ADDR_W-1:0];
        next_q.act_line    = q.ovl_line[LVF_LINE_OFS_W-1:0];
        next_q.act_x       = q.ovl_x;
        next_q.act_y       = q.ovl_y;
        next_q.commit_pend = 1'b0;
      end
    end else if (!ovl_en) begin
      next_q.ovl_on = 1'b0;
    end
    // A new Y write beats a commit in the same cycle
    if (ypos_wr) begin
      next_q.commit_pend = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{wst: LVF_IDLE, rst: LVF_IDLE, bresp: LVF_RESP_OKAY, rresp: LVF_RESP_OKAY,
             rdata: LVF_RST_REG, mode: LVF_RST_REG, vsync: LVF_RST_REG,
             main_start: LVF_RST_REG, main_line: LVF_RST_REG, ovl_start: LVF_RST_REG,
             ovl_line: LVF_RST_REG, ovl_x: LVF_RST_REG, ovl_y: LVF_RST_REG,
             vtiming: LVF_RST_REG, vdisp: LVF_RST_REG, act_start: 17'h00000,
             act_line: 10'h000, act_x: LVF_RST_REG, act_y: LVF_RST_REG,
             commit_pend: 1'b0, line: 10'h000, blank: 1'b0, ovl_on: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign vertical_non_display = q.blank;
  assign overlay_fetch_en     = q.ovl_on;
  assign overlay_x_start      = q.act_x[LVF_POS_W-1:0];
  assign overlay_x_end        = q.act_x[LVF_HI_LSB +: LVF_POS_W];

  lvf_vsync_gen u_vsync (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .line_strobe         (line_strobe),
    .line_next           (line_n),
    .vsync_start_line    (q.vsync[LVF_POS_W-1:0]),
    .vsync_width         (q.vsync[LVF_VS_WIDTH_LSB +: LVF_VS_WIDTH_W]),
    .vsync_polarity      (q.vsync[LVF_VS_POL_BIT]),
    .panel_vertical_sync (panel_vertical_sync)
  );

  lvf_fetch_addr u_main_fetch (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .load        (main_load),
    .step        (main_step),
    .base_addr   (q.main_start[LVF_ADDR_W-1:0]),
    .line_offset (q.main_line[LVF_LINE_OFS_W-1:0]),
    .fetch_addr  (main_fetch_addr)
  );

  lvf_fetch_addr u_ovl_fetch (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .load        (ovl_load),
    .step        (ovl_step),
    .base_addr   (q.act_start),
    .line_offset (q.act_line),
    .fetch_addr  (overlay_fetch_addr)
  );

  sequence s_ypos_write;
    ypos_wr;
  endsequence

  sequence s_blank_strobe;
    line_strobe && !in_disp_n;
  endsequence

  a_commit_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(q.act_y) |-> $past(q.commit_pend) && $past(line_strobe) && $past(!in_disp_n))
    else $error("overlay settings applied outside a blank line or without a Y write");
  a_commit_arm: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ypos_write ##1 (!line_strobe)[*1] |-> q.commit_pend)
    else $error("Y position write did not arm overlay update");
  a_commit_apply: assert property (@(posedge mclk) disable iff (!rst_n)
    q.commit_pend && !ypos_wr ##0 s_blank_strobe |=> q.act_y == $past(q.ovl_y) && !q.commit_pend)
    else $error("pending overlay update not applied on blank line");
  a_overlay_gated: assert property (@(posedge mclk) disable iff (!rst_n)
    !ovl_en |=> !overlay_fetch_en)
    else $error("overlay fetch active while disabled");
  a_frame_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    line_strobe && q.line == vt |=> q.line == 10'h000)
    else $error("line counter did not restart after vertical total");
  a_x_shadowed: assert property (@(posedge mclk) disable iff (!rst_n)
    !(q.commit_pend && line_strobe && !in_disp_n) |=> $stable(overlay_x_start)
      && $stable(overlay_x_end))
    else $error("overlay X outputs moved without a commit");
  a_blank_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    line_strobe |=> vertical_non_display == $past(!in_disp_n))
    else $error("non-display flag not updated on the line strobe");
  // Each answer comes one cycle after the take and stands until the master takes it
  a_write_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    wr |=> bvalid)
    else $error("write response missing one cycle after the write");
  a_write_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");
  a_read_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    rd |=> rvalid && !arready)
    else $error("read data missing one cycle after the read");
  a_read_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped or changed before it was taken");
endmodule : lvf_core
`default_nettype wire

/* test/lvf_panel_model.sv */
// Panel side line timing source feeding one strobe per line
`default_nettype none
module lvf_panel_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic slow,
  output logic      line_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] gap;
  // Gap of four cycles at least, so each line settles before the next
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap         <= 4'h0;
      line_strobe <= 1'b0;
    end else if (run && gap == 4'h0) begin
      gap         <= slow ? 4'h9 : 4'h3;
      line_strobe <= 1'b1;
    end else begin
      gap         <= run ? gap - 4'h1 : 4'h0;
      line_strobe <= 1'b0;
    end
  end
endmodule : lvf_panel_model
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the vertical sync and fetch address block
`default_nettype none
module tb
  import lvf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  REGS [6] = '{LVF_OFS_VSYNC, LVF_OFS_MAIN_START, LVF_OFS_MAIN_LINE,
                                       LVF_OFS_OVL_START, LVF_OFS_OVL_LINE, LVF_OFS_OVL_X};
  localparam logic [31:0] MASKS [6] = '{LVF_MASK_VSYNC, LVF_MASK_ADDR, LVF_MASK_LINE,
                                        LVF_MASK_ADDR, LVF_MASK_LINE, LVF_MASK_POS};
  logic        mclk = 1'b0;
  logic        rst_n, awvalid, wvalid, bready, arvalid, rready, run, slow;
  logic        awready, wready, bvalid, arready, rvalid, line_strobe, vsync, nondisp, ofe;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] wdata, rdata, seed, rd, wd;
  logic [16:0] mfa, ofa, m_base, o_base, c_base;
  logic [9:0]  oxs, oxe, m_ofs, o_ofs, x_s, x_e, y_s, y_e, vs_start, ln;
  logic [9:0]  c_ofs, c_xs, c_xe, c_ys, c_ye;
  logic [2:0]  vs_w;
  logic        pol, en, pend;
  int          bad_count, samples_checked, cnt;

  always #5 mclk = ~mclk;

  lvf_core DUT (
    .mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .line_strobe(line_strobe), .panel_vertical_sync(vsync),
    .vertical_non_display(nondisp), .main_fetch_addr(mfa), .overlay_fetch_addr(ofa),
    .overlay_fetch_en(ofe), .overlay_x_start(oxs), .overlay_x_end(oxe)
  );
  lvf_panel_model panel (.mclk(mclk), .rst_n(rst_n), .run(run), .slow(slow),
                         .line_strobe(line_strobe));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [16:0] step_addr(input logic [16:0] b, input logic [9:0] o,
                                            input logic [9:0] k);
    logic [31:0] t;
    t = 32'(b) + 32'(o) * 32'(k);
    return t[16:0];
  endfunction : step_addr

  function automatic logic sync_exp(input logic [9:0] l);
    return (l >= vs_start && l <= vs_start + 10'(vs_w)) ? pol : ~pol;
  endfunction : sync_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge mclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : do_reset

  // Tracks the line counter and the shadow commit alongside the design
  task automatic run_lines(input int n);
    logic       d;
    logic       o;
    logic [9:0] r;
    run <= 1'b1;
    for (int i = 0; i < n; i++) begin
      do @(posedge mclk); while (line_strobe !== 1'b1);
      if (i == n - 1) run <= 1'b0;
      cnt++;
      ln = (ln == 10'd19) ? 10'd0 : ln + 10'd1;
      d = ln >= 10'd4 && ln <= 10'd13;
      r = ln - 10'd4;
      if (pend && !d) begin
        {c_base, c_ofs, c_xs, c_xe, c_ys, c_ye} = {o_base, o_ofs, x_s, x_e, y_s, y_e};
        pend = 1'b0;
      end
      o = en && d && r >= c_ys && r <= c_ye;
      repeat (2) @(posedge mclk);
      #1;
      check(nondisp, !d);
      if (d) check(mfa, step_addr(m_base, m_ofs, r));
      if (cnt >= 20 || vs_start != 10'd0) check(vsync, sync_exp(ln));
      check(ofe, o);
      if (o) check(ofa, step_addr(c_base, c_ofs, r - c_ys));
      check({oxe, oxs}, {c_xe, c_xs});
    end
  endtask : run_lines

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, run, slow} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    seed = 32'd37;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (REGS[k]) begin
      axi_rd(REGS[k]);
      check(rd, 32'h0);
      wd = rnd();
      axi_wr(REGS[k], wd, 4'hf);
      check(rsp, LVF_RESP_OKAY);
      axi_rd(REGS[k]);
      check(rd, wd & MASKS[k]);
    end
    axi_wr(LVF_OFS_MAIN_LINE, 32'h0, 4'hf);
    axi_wr(LVF_OFS_MAIN_LINE, 32'hffff_ffff, 4'h2);
    axi_rd(LVF_OFS_MAIN_LINE);
    check(rd, 32'h300);
    axi_wr(8'h08, wd, 4'hf);
    check(rsp, LVF_RESP_SLVERR);
    axi_rd(8'h04);
    check(rsp, LVF_RESP_SLVERR);
    check(rd, 32'h0);
    axi_wr(LVF_OFS_STATUS, wd, 4'hf);
    check(rsp, LVF_RESP_OKAY);
    axi_rd(LVF_OFS_STATUS);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      do_reset();
      vs_w = 3'(rnd());
      vs_start = 10'(rnd() % (20 - vs_w));
      pol = i[0];
      en = (i != 2);
      // Passive panel setup: high polarity, start at line zero
      if (i == 0) begin
        vs_start = 10'd0;
        pol = 1'b1;
      end
      m_base = 17'(rnd() >> 2);
      o_base = 17'(rnd());
      m_ofs = (i == 3) ? 10'h3ff : 10'(rnd());
      o_ofs = 10'(rnd());
      x_s = 10'(rnd());
      x_e = 10'(rnd());
      y_s = 10'(rnd() % 10);
      y_e = y_s + 10'(rnd() % (10 - y_s));
      slow <= i[0];
      axi_wr(LVF_OFS_VTIMING, {6'h0, 10'd9, 6'h0, 10'd19}, 4'hf);
      axi_wr(LVF_OFS_VDISP, 32'd4, 4'hf);
      axi_wr(LVF_OFS_VSYNC, {8'h0, pol, 4'h0, vs_w, 6'h0, vs_start}, 4'hf);
      axi_wr(LVF_OFS_MAIN_START, {15'h0, m_base}, 4'hf);
      axi_wr(LVF_OFS_MAIN_LINE, {22'h0, m_ofs}, 4'hf);
      axi_wr(LVF_OFS_MODE, {12'h0, en, 19'h0}, 4'hf);
      axi_wr(LVF_OFS_OVL_START, {15'h0, o_base}, 4'hf);
      axi_wr(LVF_OFS_OVL_LINE, {22'h0, o_ofs}, 4'hf);
      axi_wr(LVF_OFS_OVL_X, {6'h0, x_e, 6'h0, x_s}, 4'hf);
      {c_base, c_ofs, c_xs, c_xe, c_ys, c_ye} = '0;
      pend = 1'b0;
      ln = 10'd0;
      cnt = 0;
      run_lines(20);
      // One round never arms the shadow, so nothing may move
      if (i != 1) begin
        axi_wr(LVF_OFS_OVL_Y, {6'h0, y_e, 6'h0, y_s}, 4'hf);
        pend = 1'b1;
      end
      axi_rd(LVF_OFS_STATUS);
      check(rd, {20'h0, pend, 1'b1, ln});
      run_lines(40);
    end
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
